//--- hw/fcb_host.sv
`timescale 1ns/100ps
`default_nettype none

module fcb_host (
    // clock and reset
    input  wire logic                       CLK_IN,
    input  wire logic                       RST_N_IN,
    // user request port
    input  wire logic                       REQ_IN,
    input  wire fcb_pkg::fcb_op_t           OP_IN,
    input  wire logic [fcb_pkg::ADDR_W-1:0] ADDR_IN,
    input  wire logic [fcb_pkg::DATA_W-1:0] WDATA_IN,
    output logic                            READY_OUT,
    output logic                            DONE_OUT,
    output logic [fcb_pkg::DATA_W-1:0]      RDATA_OUT,
    // flash pins
    output logic [fcb_pkg::ADDR_W-1:0]      FL_ADDR_OUT,
    input  wire logic [fcb_pkg::DATA_W-1:0] FL_DQ_IN,
    output logic [fcb_pkg::DATA_W-1:0]      FL_DQ_OUT,
    output logic                            FL_DQ_OE_N_OUT,
    output logic                            FL_CHIP_SELECT0_N_OUT,
    output logic                            FL_CHIP_SELECT1_N_OUT,
    output logic                            FL_OE_N_OUT,
    output logic                            FL_WE_N_OUT,
    output logic                            FL_RESET_POWERDOWN_N_OUT,
    input  wire logic                       FL_BUSY_STATUS_IN
);

    typedef enum logic [2:0] {
        S_WAKE, S_IDLE, S_MODE, S_READ, S_CMD, S_DATA, S_SETTLE, S_BUSY
    } fcb_state_t;

    fcb_state_t                 state_q, state_d;
    fcb_pkg::fcb_mode_t         mode_q, mode_d;
    fcb_pkg::fcb_op_t           op_q, op_d;
    logic [fcb_pkg::CNT_W-1:0]  cnt_q, cnt_d;
    logic [fcb_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [fcb_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic                       done_q, done_d, pend_q, rp_n_q;
    logic                       ce_n;

    fcb_cyc_if cyc ();

    // ==========================================================
    // pin engine
    fcb_bus_cycle u_cycle (
        .clk_in      (CLK_IN),
        .rst_n_in    (RST_N_IN),
        .cyc         (cyc.eng),
        .addr_out    (FL_ADDR_OUT),
        .dq_in       (FL_DQ_IN),
        .dq_out      (FL_DQ_OUT),
        .dq_oe_n_out (FL_DQ_OE_N_OUT),
        .ce_n_out    (ce_n),
        .oe_n_out    (FL_OE_N_OUT),
        .we_n_out    (FL_WE_N_OUT)
    );

    // ==========================================================
    // cycle request decode
    wire fcb_pkg::fcb_mode_t need_mode = fcb_pkg::op_mode(op_q);
    wire issuing  = (state_q == S_MODE) || (state_q == S_CMD) ||
                    (state_q == S_DATA) || (state_q == S_READ);
    wire is_wr    = (state_q != S_READ);
    wire [fcb_pkg::DATA_W-1:0] mode_word = fcb_pkg::DATA_W'(fcb_pkg::mode_cmd(need_mode));
    wire [fcb_pkg::DATA_W-1:0] cmd1_word = fcb_pkg::DATA_W'(fcb_pkg::op_cmd1(op_q));
    wire [fcb_pkg::DATA_W-1:0] cmd2_word = fcb_pkg::DATA_W'(fcb_pkg::op_cmd2(op_q));

    // one start per state, held off until the engine answers
    assign cyc.start = issuing && !pend_q;
    assign cyc.wr    = is_wr;
    assign cyc.addr  = addr_q;
    assign cyc.wdata = (state_q == S_MODE) ? mode_word :
                       (state_q == S_CMD)  ? cmd1_word :
                       (op_q == fcb_pkg::OP_WRITE) ? wdata_q : cmd2_word;

    // ==========================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        op_d    = op_q;
        cnt_d   = cnt_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        done_d  = 1'b0;
        case (state_q)
            S_WAKE: begin
                // no access until the device has left power-down
                if (cnt_q == '0) begin
                    state_d = S_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            S_IDLE: begin
                if (REQ_IN) begin
                    op_d    = OP_IN;
                    addr_d  = ADDR_IN;
                    wdata_d = WDATA_IN;
                    if (!fcb_pkg::op_is_read(OP_IN)) begin
                        state_d = S_CMD;
                    end else if (mode_q != fcb_pkg::op_mode(OP_IN)) begin
                        state_d = S_MODE;
                    end else begin
                        state_d = S_READ;
                    end
                end
            end
            S_MODE: begin
                if (cyc.done) begin
                    mode_d  = need_mode;
                    state_d = S_READ;
                end
            end
            S_READ: begin
                if (cyc.done) begin
                    rdata_d = cyc.rdata;
                    done_d  = 1'b1;
                    state_d = S_IDLE;
                end
            end
            S_CMD: begin
                if (cyc.done) begin
                    if (fcb_pkg::op_two_step(op_q)) begin
                        state_d = S_DATA;
                    end else begin
                        // suspend and resume leave the device showing status
                        if (op_q != fcb_pkg::OP_CLR_STATUS) begin
                            mode_d = fcb_pkg::M_STATUS;
                        end
                        done_d  = 1'b1;
                        state_d = S_IDLE;
                    end
                end
            end
            S_DATA: begin
                if (cyc.done) begin
                    mode_d  = fcb_pkg::M_STATUS;
                    cnt_d   = fcb_pkg::CNT_W'(fcb_pkg::STS_CYC - 1);
                    state_d = S_SETTLE;
                end
            end
            S_SETTLE: begin
                // busy output needs time to fall after the confirm write
                if (cnt_q == '0) begin
                    state_d = S_BUSY;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            S_BUSY: begin
                if (FL_BUSY_STATUS_IN) begin
                    done_d  = 1'b1;
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    // ==========================================================
    // registers; device is assumed in array mode after reset
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            state_q <= S_WAKE;
            mode_q  <= fcb_pkg::M_ARRAY;
            op_q    <= fcb_pkg::OP_READ_ARRAY;
            cnt_q   <= fcb_pkg::CNT_W'(fcb_pkg::WAKE_CYC - 1);
            addr_q  <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            done_q  <= 1'b0;
            rp_n_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q  <= mode_d;
            op_q    <= op_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            done_q  <= done_d;
            rp_n_q  <= 1'b1;
        end
    end

    // engine request outstanding
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= cyc.start || (pend_q && !cyc.done);
        end
    end

    // ==========================================================
    // outputs; both selects move together, a single decode drives them
    assign FL_CHIP_SELECT0_N_OUT    = ce_n;
    assign FL_CHIP_SELECT1_N_OUT    = ce_n;
    assign FL_RESET_POWERDOWN_N_OUT = rp_n_q;
    assign READY_OUT                = (state_q == S_IDLE);
    assign DONE_OUT                 = done_q;
    assign RDATA_OUT                = rdata_q;

    // ==========================================================
    // checks
    property p_read_mode;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (state_q == S_READ) && cyc.start |-> mode_q == need_mode;
    endproperty
    a_read_mode: assert property (p_read_mode)
        else $error("read issued without matching mode command");

    property p_array_after_alter;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (state_q == S_DATA) && cyc.done |=> mode_q == fcb_pkg::M_STATUS
            until (state_q == S_READ);
    endproperty
    a_array_after_alter: assert property (p_array_after_alter)
        else $error("array read assumed after modifying operation");

    property p_read_select;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        !FL_OE_N_OUT |-> !FL_CHIP_SELECT0_N_OUT && !FL_CHIP_SELECT1_N_OUT;
    endproperty
    a_read_select: assert property (p_read_select)
        else $error("output gate active without both selects");

    property p_read_pins_high;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        !FL_OE_N_OUT |-> FL_WE_N_OUT && FL_RESET_POWERDOWN_N_OUT;
    endproperty
    a_read_pins_high: assert property (p_read_pins_high)
        else $error("write strobe or reset active during read");

    property p_read_done;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (state_q == S_IDLE) && REQ_IN && (OP_IN == fcb_pkg::OP_READ_STATUS) &&
            (mode_q == fcb_pkg::M_STATUS) |-> ##[5:6] DONE_OUT;
    endproperty
    a_read_done: assert property (p_read_done)
        else $error("status read did not finish in time");

endmodule

`default_nettype wire

//--- hw/fcb_pkg.sv
package fcb_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int CMD_W  = 8;
    localparam int CNT_W  = 8;

    // ==========================================================
    // timing, in ns as specified, then whole clock cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_WE_NS       = 70;    // write strobe low time
    localparam int T_ACC_NS      = 150;   // output gate low to data valid
    localparam int T_WAKE_NS     = 1500;  // reset release to first access
    localparam int T_STS_NS      = 200;   // confirm write to busy output valid

    // least time rounded up, never under one cycle
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WE_CYC   = cyc_min(T_WE_NS);
    localparam int ACC_CYC  = cyc_min(T_ACC_NS);
    localparam int WAKE_CYC = cyc_min(T_WAKE_NS);
    localparam int STS_CYC  = cyc_min(T_STS_NS);

    // ==========================================================
    // command codes written into the command_user_interface
    localparam logic [CMD_W-1:0] CMD_READ_ARRAY  = 8'hff;
    localparam logic [CMD_W-1:0] CMD_READ_STATUS = 8'h70;
    localparam logic [CMD_W-1:0] CMD_READ_ID     = 8'h90;
    localparam logic [CMD_W-1:0] CMD_QUERY       = 8'h98;
    localparam logic [CMD_W-1:0] CMD_WRITE       = 8'h40;
    localparam logic [CMD_W-1:0] CMD_ERASE       = 8'h20;
    localparam logic [CMD_W-1:0] CMD_CONFIRM     = 8'hd0;
    localparam logic [CMD_W-1:0] CMD_LOCK        = 8'h60;
    localparam logic [CMD_W-1:0] CMD_LOCK_SET    = 8'h01;
    localparam logic [CMD_W-1:0] CMD_SUSPEND     = 8'hb0;
    localparam logic [CMD_W-1:0] CMD_RESUME      = 8'hd0;
    localparam logic [CMD_W-1:0] CMD_CLR_STATUS  = 8'h50;

    // ==========================================================
    // user operations and device read modes
    typedef enum logic [3:0] {
        OP_READ_ARRAY, OP_READ_STATUS, OP_READ_ID, OP_QUERY,
        OP_WRITE, OP_ERASE, OP_LOCK_SET, OP_LOCK_CLEAR,
        OP_SUSPEND, OP_RESUME, OP_CLR_STATUS
    } fcb_op_t;

    typedef enum logic [1:0] {
        M_ARRAY, M_STATUS, M_ID, M_QUERY
    } fcb_mode_t;

    function automatic logic op_is_read(input fcb_op_t op);
        return (op == OP_READ_ARRAY) || (op == OP_READ_STATUS) ||
               (op == OP_READ_ID) || (op == OP_QUERY);
    endfunction

    function automatic logic op_two_step(input fcb_op_t op);
        return (op == OP_WRITE) || (op == OP_ERASE) ||
               (op == OP_LOCK_SET) || (op == OP_LOCK_CLEAR);
    endfunction

    function automatic fcb_mode_t op_mode(input fcb_op_t op);
        case (op)
            OP_READ_STATUS: return M_STATUS;
            OP_READ_ID:     return M_ID;
            OP_QUERY:       return M_QUERY;
            default:        return M_ARRAY;
        endcase
    endfunction

    function automatic logic [CMD_W-1:0] mode_cmd(input fcb_mode_t m);
        case (m)
            M_STATUS: return CMD_READ_STATUS;
            M_ID:     return CMD_READ_ID;
            M_QUERY:  return CMD_QUERY;
            default:  return CMD_READ_ARRAY;
        endcase
    endfunction

    function automatic logic [CMD_W-1:0] op_cmd1(input fcb_op_t op);
        case (op)
            OP_WRITE:      return CMD_WRITE;
            OP_ERASE:      return CMD_ERASE;
            OP_LOCK_SET:   return CMD_LOCK;
            OP_LOCK_CLEAR: return CMD_LOCK;
            OP_SUSPEND:    return CMD_SUSPEND;
            OP_RESUME:     return CMD_RESUME;
            default:       return CMD_CLR_STATUS;
        endcase
    endfunction

    function automatic logic [CMD_W-1:0] op_cmd2(input fcb_op_t op);
        return (op == OP_LOCK_SET) ? CMD_LOCK_SET : CMD_CONFIRM;
    endfunction

endpackage

//--- hw/fcb_cyc_if.sv
`timescale 1ns/100ps
`default_nettype none

// one bus cycle request from the sequencer to the pin engine
interface fcb_cyc_if;
    logic                           start;
    logic                           wr;
    logic [fcb_pkg::ADDR_W-1:0]     addr;
    logic [fcb_pkg::DATA_W-1:0]     wdata;
    logic                           done;
    logic [fcb_pkg::DATA_W-1:0]     rdata;

    modport ctl (output start, output wr, output addr, output wdata,
                 input done, input rdata);
    modport eng (input start, input wr, input addr, input wdata,
                 output done, output rdata);
endinterface

`default_nettype wire

//--- hw/fcb_bus_cycle.sv
`timescale 1ns/100ps
`default_nettype none

module fcb_bus_cycle (
    // clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    // request side
    fcb_cyc_if.eng                          cyc,
    // flash pins
    output logic [fcb_pkg::ADDR_W-1:0]      addr_out,
    input  wire logic [fcb_pkg::DATA_W-1:0] dq_in,
    output logic [fcb_pkg::DATA_W-1:0]      dq_out,
    output logic                            dq_oe_n_out,
    output logic                            ce_n_out,
    output logic                            oe_n_out,
    output logic                            we_n_out
);

    typedef enum logic [1:0] {E_IDLE, E_STROBE, E_HOLD} fcb_eng_t;

    fcb_eng_t                   state_q, state_d;
    logic [fcb_pkg::CNT_W-1:0]  cnt_q, cnt_d;
    logic                       wr_q, wr_d;
    logic                       ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
    logic                       dq_oe_n_q, dq_oe_n_d, done_q, done_d;
    logic [fcb_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [fcb_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;

    // ==========================================================
    // strobe sequencing
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        wr_d      = wr_q;
        ce_n_d    = ce_n_q;
        oe_n_d    = oe_n_q;
        we_n_d    = we_n_q;
        dq_oe_n_d = dq_oe_n_q;
        addr_d    = addr_q;
        wdata_d   = wdata_q;
        rdata_d   = rdata_q;
        done_d    = 1'b0;
        case (state_q)
            E_IDLE: begin
                if (cyc.start) begin
                    // address and data held in our flops for the whole cycle
                    addr_d  = cyc.addr;
                    wdata_d = cyc.wdata;
                    wr_d    = cyc.wr;
                    ce_n_d  = 1'b0;
                    state_d = E_STROBE;
                    if (cyc.wr) begin
                        we_n_d    = 1'b0;
                        dq_oe_n_d = 1'b0;
                        cnt_d     = fcb_pkg::CNT_W'(fcb_pkg::WE_CYC - 1);
                    end else begin
                        oe_n_d = 1'b0;
                        cnt_d  = fcb_pkg::CNT_W'(fcb_pkg::ACC_CYC - 1);
                    end
                end
            end
            E_STROBE: begin
                if (cnt_q == '0) begin
                    state_d = E_HOLD;
                    if (wr_q) begin
                        we_n_d = 1'b1;    // rising edge latches addr and data
                    end else begin
                        oe_n_d  = 1'b1;
                        rdata_d = dq_in;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            E_HOLD: begin
                // data and select stay one cycle past the rising edge for hold
                ce_n_d    = 1'b1;
                dq_oe_n_d = 1'b1;
                done_d    = 1'b1;
                state_d   = E_IDLE;
            end
            default: state_d = E_IDLE;
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q   <= E_IDLE;
            cnt_q     <= '0;
            wr_q      <= 1'b0;
            ce_n_q    <= 1'b1;
            oe_n_q    <= 1'b1;
            we_n_q    <= 1'b1;
            dq_oe_n_q <= 1'b1;
            done_q    <= 1'b0;
            addr_q    <= '0;
            wdata_q   <= '0;
            rdata_q   <= '0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            wr_q      <= wr_d;
            ce_n_q    <= ce_n_d;
            oe_n_q    <= oe_n_d;
            we_n_q    <= we_n_d;
            dq_oe_n_q <= dq_oe_n_d;
            done_q    <= done_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            rdata_q   <= rdata_d;
        end
    end

    // ==========================================================
    // outputs
    assign addr_out    = addr_q;
    assign dq_out      = wdata_q;
    assign dq_oe_n_out = dq_oe_n_q;
    assign ce_n_out    = ce_n_q;
    assign oe_n_out    = oe_n_q;
    assign we_n_out    = we_n_q;
    assign cyc.done    = done_q;
    assign cyc.rdata   = rdata_q;

    // ==========================================================
    // checks
    property p_no_we_in_read;
        @(posedge clk_in) disable iff (!rst_n_in)
        !oe_n_q |-> we_n_q && dq_oe_n_q;
    endproperty
    a_no_we_in_read: assert property (p_no_we_in_read)
        else $error("write strobe or data drive during read");

    property p_read_len;
        @(posedge clk_in) disable iff (!rst_n_in)
        $fell(oe_n_q) |-> !oe_n_q [*2] ##1 oe_n_q ##1 done_q;
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read strobe length or done wrong");

endmodule

`default_nettype wire

//--- dv/fcb_flash_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// flash device model
module fcb_flash_model #(
    parameter int          BUSY_NS = 900,
    parameter logic [15:0] ID_CODE = 16'h005a  // arbitrary value
) (
    // flash pins
    input  wire logic [20:0] addr_in,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    input  wire logic        cs0_n_in,
    input  wire logic        cs1_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic        rp_n_in,
    output logic             busy_n_out,
    // program supply at its high level
    input  wire logic        vpp_ok_in
);
    logic [15:0] mem [int];
    logic [31:0] lock_q = '0;
    logic [7:0]  pend   = 8'h00;
    logic [7:0]  cmd;
    logic [4:0]  blk;
    logic [15:0] rd;
    int          mode   = 0;
    initial busy_n_out = 1'b1;

    // read source follows the last mode command, supply level ignored
    always @* begin
        case (mode)
            1: rd = {8'h00, busy_n_out, 7'h00};
            2: rd = ID_CODE;
            3: rd = 16'h0051;
            default: rd = mem.exists(addr_in[20:1]) ? mem[addr_in[20:1]] : 16'hffff;
        endcase
    end
    // released bus shows the inverse so a stale word never passes
    assign dq_out = (rp_n_in && !cs0_n_in && !cs1_n_in && !oe_n_in) ? rd : ~rd;

    // leaving power-down returns to array reads
    always @(posedge rp_n_in) begin
        mode = 0;
        pend = 8'h00;
    end

    // internal sequencer: pulses and verify hidden behind busy
    task automatic run_op();
        mode = 1;
        busy_n_out = 1'b0;
        #(BUSY_NS);
        busy_n_out = 1'b1;
    endtask

    // address and data taken at the strobe's rising edge
    always @(posedge we_n_in) begin
        if (rp_n_in && !cs0_n_in && !cs1_n_in) begin
            cmd = dq_in[7:0];
            blk = addr_in[20:16];
            case (pend)
                fcb_pkg::CMD_WRITE: begin
                    if (vpp_ok_in && !lock_q[blk]) mem[addr_in[20:1]] = dq_in;
                    run_op();
                end
                fcb_pkg::CMD_ERASE: begin
                    if (cmd == fcb_pkg::CMD_CONFIRM) begin
                        for (int i = 0; i < 32768 && vpp_ok_in && !lock_q[blk]; i++) begin
                            mem.delete(blk * 32768 + i);
                        end
                        run_op();
                    end
                end
                fcb_pkg::CMD_LOCK: begin
                    if (vpp_ok_in && cmd == fcb_pkg::CMD_LOCK_SET) lock_q[blk] = 1'b1;
                    else if (vpp_ok_in) lock_q = '0;
                    run_op();
                end
                default: begin
                    if (cmd == fcb_pkg::CMD_READ_ARRAY) mode = 0;
                    if (cmd == fcb_pkg::CMD_READ_STATUS) mode = 1;
                    if (cmd == fcb_pkg::CMD_READ_ID) mode = 2;
                    if (cmd == fcb_pkg::CMD_QUERY) mode = 3;
                    // suspend and resume show status; other blocks stay readable
                    if (cmd inside {fcb_pkg::CMD_SUSPEND, fcb_pkg::CMD_RESUME}) mode = 1;
                end
            endcase
            pend = (pend == 8'h00 && cmd inside {8'h40, 8'h20, 8'h60}) ? cmd : 8'h00;
        end
    end
endmodule

`default_nettype wire

//--- dv/fcb_host_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module fcb_host_tb_top;
    localparam logic [15:0] ID_VAL = 16'h005a;  // arbitrary value
    logic CLK_IN = 1'b0;
    logic RST_N_IN = 1'b0;
    logic REQ_IN = 1'b0;
    fcb_pkg::fcb_op_t OP_IN = fcb_pkg::OP_READ_ARRAY;
    logic [20:0] ADDR_IN = '0;
    logic [15:0] WDATA_IN = '0;
    logic vpp_ok = 1'b1;
    logic rdy, done, oe_dq, cs0, cs1, oe, we, rp, busy;
    logic [15:0] rdata, dq_o, dq_i;
    logic [20:0] fa, a;
    logic [15:0] ref_mem [int];
    logic [31:0] ref_lock = '0;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #50 CLK_IN = ~CLK_IN;

    fcb_host uut (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .REQ_IN(REQ_IN), .OP_IN(OP_IN),
        .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .READY_OUT(rdy), .DONE_OUT(done),
        .RDATA_OUT(rdata), .FL_ADDR_OUT(fa), .FL_DQ_IN(dq_i), .FL_DQ_OUT(dq_o),
        .FL_DQ_OE_N_OUT(oe_dq), .FL_CHIP_SELECT0_N_OUT(cs0), .FL_CHIP_SELECT1_N_OUT(cs1),
        .FL_OE_N_OUT(oe), .FL_WE_N_OUT(we), .FL_RESET_POWERDOWN_N_OUT(rp),
        .FL_BUSY_STATUS_IN(busy));
    fcb_flash_model #(.BUSY_NS(900), .ID_CODE(ID_VAL)) dev (.addr_in(fa), .dq_in(dq_o),
        .dq_out(dq_i), .cs0_n_in(cs0), .cs1_n_in(cs1), .oe_n_in(oe), .we_n_in(we),
        .rp_n_in(rp), .busy_n_out(busy), .vpp_ok_in(vpp_ok));

    task automatic test_done();
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one user request, bounded waits for ready and done
    task automatic run(input fcb_pkg::fcb_op_t op, input logic [20:0] ad, input logic [15:0] d);
        @(negedge CLK_IN);
        for (int n = 0; n < 100 && rdy !== 1'b1; n++) @(negedge CLK_IN);
        OP_IN = op;
        ADDR_IN = ad;
        WDATA_IN = d;
        REQ_IN = 1'b1;
        @(negedge CLK_IN);
        REQ_IN = 1'b0;
        for (int n = 0; n < 300 && done !== 1'b1; n++) @(negedge CLK_IN);
    endtask

    task automatic rd(input fcb_pkg::fcb_op_t op, input logic [20:0] ad, input logic [15:0] e);
        run(op, ad, 16'h0000);
        check(rdata, e);
    endtask

    // reference array: erased words read as all ones
    task automatic rd_arr(input logic [20:0] ad);
        rd(fcb_pkg::OP_READ_ARRAY, ad, ref_mem.exists(ad[20:1]) ? ref_mem[ad[20:1]] : 16'hffff);
    endtask

    task automatic wr(input logic [20:0] ad, input logic [15:0] d);
        run(fcb_pkg::OP_WRITE, ad, d);
        if (vpp_ok && !ref_lock[ad[20:16]]) ref_mem[ad[20:1]] = d;
    endtask

    task automatic erase(input logic [20:0] ad);
        run(fcb_pkg::OP_ERASE, ad, 16'h0000);
        for (int i = 0; i < 32768 && vpp_ok && !ref_lock[ad[20:16]]; i++) begin
            ref_mem.delete(ad[20:16] * 32768 + i);
        end
    endtask

    // read cycles need both selects, strobe and reset high, bus released
    always @(negedge CLK_IN) begin
        cyc++;
        if (oe === 1'b0) check({11'h000, cs0, cs1, we, rp, oe_dq}, 16'h0007);
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'hb4fd4379));
        repeat (10) @(negedge CLK_IN);
        RST_N_IN = 1'b1;
        rd_arr(21'h0abcde);
        // random words across blocks, read back through array mode
        for (int i = 0; i < 6; i++) begin
            a = 21'($urandom());
            a[0] = 1'b0;
            wr(a, 16'($urandom()));
            rd_arr(a);
        end
        // low program supply: reads still work, array unaltered
        vpp_ok = 1'b0;
        rd(fcb_pkg::OP_READ_STATUS, 21'h000000, 16'h0080);
        rd(fcb_pkg::OP_READ_ID, 21'h000000, ID_VAL);
        rd(fcb_pkg::OP_QUERY, 21'h000020, 16'h0051);
        wr(21'h033330, 16'h1234);
        rd_arr(21'h033330);
        vpp_ok = 1'b1;
        // erase at the block boundary leaves the neighbour intact
        wr(21'h04fffe, 16'ha5a5);
        wr(21'h050000, 16'h5a5a);
        erase(21'h05fffe);
        rd_arr(21'h050000);
        rd_arr(21'h04fffe);
        // locked block refuses write and erase until cleared
        wr(21'h070100, 16'h0f0f);
        run(fcb_pkg::OP_LOCK_SET, 21'h07ff00, 16'h0000);
        ref_lock[7] = 1'b1;
        wr(21'h070100, 16'hf0f0);
        erase(21'h070000);
        rd_arr(21'h070100);
        run(fcb_pkg::OP_LOCK_CLEAR, 21'h000000, 16'h0000);
        ref_lock = '0;
        wr(21'h070100, 16'h3c3c);
        rd_arr(21'h070100);
        // suspend and resume leave status showing, other blocks still readable
        run(fcb_pkg::OP_SUSPEND, 21'h000000, 16'h0000);
        rd(fcb_pkg::OP_READ_STATUS, 21'h000000, 16'h0080);
        rd_arr(21'h04fffe);
        run(fcb_pkg::OP_RESUME, 21'h000000, 16'h0000);
        rd(fcb_pkg::OP_READ_STATUS, 21'h000000, 16'h0080);
        run(fcb_pkg::OP_CLR_STATUS, 21'h000000, 16'h0000);
        // mid-run reset drops the device back to array reads
        rd(fcb_pkg::OP_READ_STATUS, 21'h000000, 16'h0080);
        @(negedge CLK_IN);
        RST_N_IN = 1'b0;
        repeat (2) @(negedge CLK_IN);
        RST_N_IN = 1'b1;
        rd_arr(21'h070100);
        test_done();
    end
endmodule

`default_nettype wire
